// ==== core/scope_serial_command_interpreter.v ====
`timescale 1ns/1ps
`include "scope_cmd_map.vh"
module scope_serial_command_interpreter (
	input wire clk_in, // 10 MHz clock
	input wire sys_rst_in, // synchronous reset, high
	input wire wb_cyc_in, // wishbone cycle
	input wire wb_stb_in, // wishbone strobe
	input wire wb_we_in, // wishbone write
	input wire [4:0] wb_adr_in, // wishbone byte address
	input wire [3:0] wb_sel_in, // wishbone byte lanes
	input wire [31:0] wb_dat_in, // wishbone write data
	output reg [31:0] wb_dat_out, // wishbone read data
	output reg wb_ack_out, // wishbone acknowledge
	input wire [7:0] rx_char_in, // received character
	input wire rx_valid_in, // received character strobe
	output reg [7:0] tx_char_out, // character to send
	output reg tx_valid_out, // character valid
	input wire tx_ready_in, // sender takes character
	output reg io_active_out, // interface enabled
	output reg go_live_out, // plug-in live pulse
	output reg hold_next_out, // hold after next sweep pulse
	output reg sweep_abort_out, // sweep abort pulse
	output reg autocycle_out, // autocycle start pulse
	output reg recall_out, // disk recall pulse
	output reg store_out, // disk store pulse
	output reg select_out, // disk track select pulse
	output reg [3:0] track_out // track for disk pulses
);
	localparam [3:0] S_OFF = 4'h0;
	localparam [3:0] S_CMD = 4'h1;
	localparam [3:0] S_ARG = 4'h2;
	localparam [3:0] S_SOLO = 4'h3;
	localparam [3:0] S_SEND = 4'h4;
	localparam [3:0] S_XFER = 4'h5;
	localparam [3:0] S_ADDR = 4'h6;
	localparam [3:0] S_NOUT = 4'h7;
	localparam [3:0] S_NIN = 4'h8;

	reg [11:0] panel;
	reg [11:0] waddr;
	reg [12:0] xcount;
	reg [11:0] wave [0:4095];
	reg [7:0] nstd [0:215];
	reg [7:0] nrst [0:215];
	reg [3:0] state;
	reg [3:0] after_send;
	reg [7:0] cmd_letter;
	reg [1:0] mode;
	reg xwave;
	reg xnorm;
	reg prev_load;
	reg [11:0] addr_ctr;
	reg [12:0] left;
	reg [1:0] nsel;
	reg [7:0] nidx;
	reg [4:0] npos;
	reg [13:0] acc;
	reg [2:0] acnt;
	reg ierr;
	reg terming;
	reg rs;
	reg rs_clr;
	reg abort_flag;
	reg live_q;
	reg dact_q;
	reg [7:0] seq [0:7];
	reg [3:0] seq_len;
	reg [3:0] seq_idx;

	wire wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
	wire [7:0] rx_dig = rx_char_in - `CH_ZERO;
	wire rx_isdig = (rx_char_in >= `CH_ZERO) && (rx_char_in <= `CH_NINE);
	wire [3:0] ptrack = panel[`PNL_TRK_HI:`PNL_TRK_LO];
	wire [2:0] memsw = panel[`PNL_MEM_HI:`PNL_MEM_LO];
	wire [13:0] acc_next = acc * 14'd10 + {6'h00, rx_dig};
	wire [7:0] nout_char = (nsel == 2'h2) ? nrst[nidx] : nstd[nidx];
	// lights as status bits
	wire [7:0] short_stat = `STAT_BASE | {5'h00, panel[`PNL_DERR], panel[`PNL_DACT],
		panel[`PNL_LIVE]};
	// byte-lane merges for writes
	wire [15:0] wr_panel = {wb_sel_in[1] ? wb_dat_in[15:8] : {4'h0, panel[11:8]},
		wb_sel_in[0] ? wb_dat_in[7:0] : panel[7:0]};
	wire [15:0] wr_waddr = {wb_sel_in[1] ? wb_dat_in[15:8] : {4'h0, waddr[11:8]},
		wb_sel_in[0] ? wb_dat_in[7:0] : waddr[7:0]};
	wire [15:0] wr_xcount = {wb_sel_in[1] ? wb_dat_in[15:8] : {3'h0, xcount[12:8]},
		wb_sel_in[0] ? wb_dat_in[7:0] : xcount[7:0]};

	// printable binary byte to six-bit group, parity bit dropped
	function [5:0] pb6;
		input [7:0] c;
		reg [7:0] t;
		begin
			t = {1'b0, c[6:0]} - `PB_OFFSET;
			pb6 = t[5:0];
		end
	endfunction

	// six-bit group to printable byte
	function [7:0] pbc;
		input [5:0] g;
		begin
			pbc = {2'h0, g} + `PB_OFFSET;
		end
	endfunction

	// one decimal digit character
	function [7:0] dig;
		input [11:0] q;
		begin
			dig = `CH_ZERO | {4'h0, q[3:0]};
		end
	endfunction

	// sign and four digits of a 12-bit signed value
	function [39:0] dec5;
		input [11:0] v;
		reg [11:0] m;
		begin
			m = v[11] ? (~v + 12'h001) : v;
			dec5 = {v[11] ? `CH_MINUS : `CH_PLUS, dig(m / 12'd1000),
				dig((m / 12'd100) % 12'd10), dig((m / 12'd10) % 12'd10),
				dig(m % 12'd10)};
		end
	endfunction

	// queue bar, status and delimiter, then go quiet
	task start_term;
		input e;
		begin
			ierr <= e;
			terming <= 1'b1;
			rs_clr <= 1'b1;
			seq[0] <= `CH_BAR;
			seq[1] <= short_stat | {3'h0, rs, e, 3'h0};
			seq[2] <= `CH_CR;
			seq[3] <= `CH_LF;
			seq_len <= 4'h4;
			seq_idx <= 4'h0;
			after_send <= S_OFF;
			state <= S_SEND;
		end
	endtask

	// queue one data point in the selected code
	task load_point;
		input [11:0] v;
		reg [39:0] d;
		begin
			d = dec5(v);
			if (mode[1]) begin
				seq[0] <= pbc(v[11:6]);
				seq[1] <= pbc(v[5:0]);
				seq[2] <= `CH_CR;
				seq[3] <= `CH_LF;
				seq_len <= 4'h4;
			end else begin
				seq[0] <= d[39:32];
				seq[1] <= d[31:24];
				seq[2] <= d[23:16];
				seq[3] <= d[15:8];
				seq[4] <= d[7:0];
				seq[5] <= `CH_CR;
				seq[6] <= `CH_LF;
				seq_len <= 4'h7;
			end
			seq_idx <= 4'h0;
			left <= left - 13'h0001;
			after_send <= S_XFER;
			state <= S_SEND;
		end
	endtask

	// wishbone slave, one wait state
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
			panel <= `PANEL_RST;
			waddr <= `WADDR_RST;
			xcount <= `XCOUNT_RST;
		end else begin
			wb_ack_out <= wb_req;
			wb_dat_out <= 32'h00000000;
			if (wb_req && wb_we_in) begin
				case (wb_adr_in)
					`OFS_PANEL: panel <= wr_panel[11:0];
					`OFS_WADDR: waddr <= wr_waddr[11:0];
					`OFS_XCOUNT: xcount <= wr_xcount[12:0];
					`OFS_WDATA: begin
						if (wb_sel_in[1:0] == 2'h3) begin
							wave[waddr] <= wb_dat_in[11:0];
							waddr <= waddr + 12'h001;
						end
					end
					default: ;
				endcase
			end else if (wb_req) begin
				case (wb_adr_in)
					`OFS_PANEL: wb_dat_out <= {20'h00000, panel};
					`OFS_WADDR: wb_dat_out <= {20'h00000, waddr};
					`OFS_WDATA: wb_dat_out <= {20'h00000, wave[waddr]};
					`OFS_XCOUNT: wb_dat_out <= {19'h00000, xcount};
					`OFS_STATUS: wb_dat_out <= {4'h0, addr_ctr, 9'h000, rs, ierr,
						io_active_out, state};
					default: wb_dat_out <= 32'h00000000;
				endcase
			end
		end
	end

	// request service from disk-activity falling edges and from live falling edges except the first after a sweep abort
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			live_q <= 1'b0;
			dact_q <= 1'b0;
			abort_flag <= 1'b0;
			rs <= 1'b0;
		end else begin
			live_q <= panel[`PNL_LIVE];
			dact_q <= panel[`PNL_DACT];
			if (sweep_abort_out)
				abort_flag <= 1'b1;
			else if (live_q & ~panel[`PNL_LIVE])
				abort_flag <= 1'b0;
			// a new event wins over the clear
			if ((live_q & ~panel[`PNL_LIVE] & ~abort_flag) | (dact_q & ~panel[`PNL_DACT]))
				rs <= 1'b1;
			else if (rs_clr)
				rs <= 1'b0;
		end
	end

	// interface enable indicator
	always @(posedge clk_in) begin
		if (sys_rst_in)
			io_active_out <= 1'b0;
		else
			io_active_out <= (state != S_OFF);
	end

	// command interpreter
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			state <= S_OFF;
			after_send <= S_OFF;
			cmd_letter <= 8'h00;
			mode <= 2'h0;
			xwave <= 1'b0;
			xnorm <= 1'b0;
			prev_load <= 1'b0;
			addr_ctr <= 12'h000;
			left <= 13'h0000;
			nsel <= 2'h0;
			nidx <= 8'h00;
			npos <= 5'h00;
			acc <= 14'h0000;
			acnt <= 3'h0;
			ierr <= 1'b0;
			terming <= 1'b0;
			rs_clr <= 1'b0;
			seq_len <= 4'h0;
			seq_idx <= 4'h0;
			tx_char_out <= 8'h00;
			tx_valid_out <= 1'b0;
			go_live_out <= 1'b0;
			hold_next_out <= 1'b0;
			sweep_abort_out <= 1'b0;
			autocycle_out <= 1'b0;
			recall_out <= 1'b0;
			store_out <= 1'b0;
			select_out <= 1'b0;
			track_out <= 4'h0;
		end else begin
			go_live_out <= 1'b0;
			hold_next_out <= 1'b0;
			sweep_abort_out <= 1'b0;
			autocycle_out <= 1'b0;
			recall_out <= 1'b0;
			store_out <= 1'b0;
			select_out <= 1'b0;
			rs_clr <= 1'b0;
			case (state)
				S_OFF: begin
					if (rx_valid_in && rx_char_in == `CH_SOH) begin
						state <= S_CMD;
						ierr <= 1'b0;
						terming <= 1'b0;
						xwave <= 1'b0;
						xnorm <= 1'b0;
						prev_load <= 1'b0;
					end
				end
				S_CMD: begin
					if (rx_valid_in) begin
						case (rx_char_in)
							`CH_ETX: start_term(1'b0);
							`CH_STX: begin
								if (xwave) begin
									left <= xcount;
									state <= S_XFER;
								end else if (xnorm) begin
									nidx <= 8'h00;
									npos <= 5'h00;
									state <= panel[`PNL_NIN] ? S_NIN : S_NOUT;
								end else
									start_term(1'b1);
							end
							`CH_CMD_L, `CH_CMD_H, `CH_CMD_R, `CH_CMD_S, `CH_CMD_T,
							`CH_CMD_D, `CH_CMD_N: begin
								cmd_letter <= rx_char_in;
								state <= S_ARG;
							end
							default: start_term(1'b1);
						endcase
					end
				end
				S_ARG: begin
					if (rx_valid_in && !rx_isdig)
						start_term(1'b1);
					else if (rx_valid_in) begin
						case (cmd_letter)
							`CH_CMD_L: begin
								if (rx_dig == 8'h00) begin
									go_live_out <= 1'b1;
									state <= S_SOLO;
								end else
									start_term(1'b1);
							end
							`CH_CMD_H: begin
								case (rx_dig)
									8'h00: begin
										go_live_out <= 1'b1;
										hold_next_out <= 1'b1;
										state <= S_SOLO;
									end
									8'h02: begin
										sweep_abort_out <= 1'b1;
										state <= S_SOLO;
									end
									8'h03: begin
										autocycle_out <= panel[`PNL_ACYC];
										state <= S_SOLO;
									end
									default: start_term(1'b1);
								endcase
							end
							`CH_CMD_D: begin
								state <= S_CMD;
								prev_load <= (rx_dig == 8'h01) || (rx_dig == 8'h03);
								if (rx_dig < 8'h04) begin
									mode <= rx_dig[1:0];
									xwave <= 1'b1;
									xnorm <= 1'b0;
									if (!rx_dig[0] && prev_load)
										addr_ctr <= 12'h000;
								end else if (rx_dig == 8'h04) begin
									seq[0] <= short_stat;
									seq_len <= 4'h1;
									seq_idx <= 4'h0;
									after_send <= S_CMD;
									state <= S_SEND;
								end else if (rx_dig == 8'h05) begin
									seq[0] <= `CH_ZERO | {4'h0, ptrack};
									seq[1] <= `CH_ZERO | {5'h00, memsw};
									seq[2] <= short_stat;
									seq_len <= 4'h3;
									seq_idx <= 4'h0;
									after_send <= S_CMD;
									state <= S_SEND;
								end else
									start_term(1'b1);
							end
							`CH_CMD_N: begin
								if (rx_dig < 8'h03) begin
									nsel <= rx_dig[1:0];
									xnorm <= 1'b1;
									xwave <= 1'b0;
									prev_load <= 1'b0;
									state <= S_CMD;
								end else
									start_term(1'b1);
							end
							default: begin
								if (rx_dig > 8'h08)
									start_term(1'b1);
								else begin
									track_out <= (rx_dig == 8'h00) ? ptrack : rx_dig[3:0];
									recall_out <= (cmd_letter == `CH_CMD_R);
									store_out <= (cmd_letter == `CH_CMD_S);
									select_out <= (cmd_letter == `CH_CMD_T) &&
										(rx_dig != 8'h00);
									state <= S_SOLO;
								end
							end
						endcase
					end
				end
				S_SOLO: begin
					if (rx_valid_in)
						start_term(rx_char_in != `CH_ETX);
				end
				S_SEND: begin
					if (!tx_valid_out || tx_ready_in) begin
						if (seq_idx != seq_len) begin
							tx_char_out <= seq[seq_idx[2:0]];
							tx_valid_out <= 1'b1;
							seq_idx <= seq_idx + 4'h1;
						end else begin
							tx_valid_out <= 1'b0;
							state <= after_send;
						end
					end
				end
				S_XFER: begin
					if (left == 13'h0000)
						start_term(1'b0);
					else if (mode[0]) begin
						acc <= 14'h0000;
						acnt <= 3'h0;
						state <= S_ADDR;
					end else begin
						load_point(wave[addr_ctr]);
						addr_ctr <= addr_ctr + 12'h001;
					end
				end
				S_ADDR: begin
					if (rx_valid_in && rx_char_in == `CH_ETX)
						start_term(1'b0);
					else if (rx_valid_in && mode[1]) begin
						if (acnt == 3'h0) begin
							acc <= {8'h00, pb6(rx_char_in)};
							acnt <= 3'h1;
						end else
							load_point(wave[{acc[5:0], pb6(rx_char_in)}]);
					end else if (rx_valid_in) begin
						if (acnt == 3'h0) begin
							if (rx_char_in == `CH_PLUS || rx_char_in == `CH_SPACE)
								acnt <= 3'h1;
							else
								start_term(1'b1);
						end else if (!rx_isdig)
							start_term(1'b1);
						else if (acnt != 3'h4) begin
							acc <= acc_next;
							acnt <= acnt + 3'h1;
						end else if (acc_next > `WAVE_LAST)
							start_term(1'b1);
						else
							load_point(wave[acc_next[11:0]]);
					end
				end
				S_NOUT: begin
					if (nidx == `NORM_TOTAL)
						start_term(1'b0);
					else begin
						seq[0] <= nout_char;
						if (npos == `NORM_SET_LAST) begin
							seq[1] <= `CH_CR;
							seq[2] <= `CH_LF;
							seq_len <= 4'h3;
							npos <= 5'h00;
						end else begin
							seq_len <= 4'h1;
							npos <= npos + 5'h01;
						end
						seq_idx <= 4'h0;
						nidx <= nidx + 8'h01;
						after_send <= S_NOUT;
						state <= S_SEND;
					end
				end
				S_NIN: begin
					if (rx_valid_in && rx_char_in == `CH_ETX)
						start_term(1'b0);
					else if (rx_valid_in && rx_char_in != `CH_CR && rx_char_in != `CH_LF) begin
						if (nsel != 2'h2)
							nstd[nidx] <= rx_char_in;
						if (nsel != 2'h1)
							nrst[nidx] <= rx_char_in;
						nidx <= nidx + 8'h01;
						if (nidx == `NORM_LAST)
							start_term(1'b0);
					end
				end
				default: state <= S_OFF;
			endcase
			// host characters while output is running
			if (rx_valid_in && (state == S_SEND || state == S_XFER || state == S_NOUT)) begin
				if (rx_char_in == `CH_ETX) begin
					tx_valid_out <= 1'b0;
					state <= S_OFF;
				end else if (!terming)
					start_term(1'b1);
			end
		end
	end
endmodule // scope_serial_command_interpreter

// ==== core/scope_cmd_map.vh ====
`ifndef SCOPE_CMD_MAP_VH
`define SCOPE_CMD_MAP_VH
// wishbone byte offsets
`define OFS_PANEL 5'h00
`define OFS_WADDR 5'h04
`define OFS_WDATA 5'h08
`define OFS_XCOUNT 5'h0c
`define OFS_STATUS 5'h10
// panel register field positions
`define PNL_LIVE 0
`define PNL_DACT 1
`define PNL_DERR 2
`define PNL_ACYC 3
`define PNL_TRK_LO 4
`define PNL_TRK_HI 7
`define PNL_MEM_LO 8
`define PNL_MEM_HI 10
`define PNL_NIN 11
// reset values
`define PANEL_RST 12'h010
`define XCOUNT_RST 13'h0000
`define WADDR_RST 12'h000
// status register field positions
`define STS_IO 4
`define STS_IERR 5
`define STS_RSVC 6
`define STS_ADDR_LO 16
// control and text characters
`define CH_SOH 8'h01
`define CH_STX 8'h02
`define CH_ETX 8'h03
`define CH_LF 8'h0a
`define CH_CR 8'h0d
`define CH_SPACE 8'h20
`define CH_PLUS 8'h2b
`define CH_MINUS 8'h2d
`define CH_ZERO 8'h30
`define CH_NINE 8'h39
`define CH_BAR 8'h7c
`define CH_CMD_D 8'h44
`define CH_CMD_H 8'h48
`define CH_CMD_L 8'h4c
`define CH_CMD_N 8'h4e
`define CH_CMD_R 8'h52
`define CH_CMD_S 8'h53
`define CH_CMD_T 8'h54
// printable binary offset
`define PB_OFFSET 8'h20
// status character layout
`define STAT_BASE 8'h40
`define ST_LIVE 0
`define ST_DACT 1
`define ST_DERR 2
`define ST_IERR 3
`define ST_RSVC 4
// waveform and normalization sizes
`define WAVE_LAST 14'd4095
`define NORM_SET_LAST 5'd26
`define NORM_LAST 8'd215
`define NORM_TOTAL 8'd216
`endif

// ==== sim/scope_cmd_checker.sv ====
`timescale 1ns/1ps
`include "scope_cmd_map.vh"
module scope_cmd_checker (
	input wire clk_in, // clock
	input wire sys_rst_in, // reset
	input wire wb_cyc_in, // cycle
	input wire wb_stb_in, // strobe
	input wire [31:0] wb_dat_out, // read data
	input wire wb_ack_out, // answer
	input wire [7:0] rx_char_in, // host char
	input wire rx_valid_in, // host strobe
	input wire [7:0] tx_char_out, // device char
	input wire tx_valid_out, // device valid
	input wire tx_ready_in, // host takes
	input wire io_active_out, // enabled
	input wire go_live_out, // live
	input wire hold_next_out, // hold next
	input wire sweep_abort_out, // abort
	input wire autocycle_out, // autocycle
	input wire recall_out, // recall
	input wire store_out, // store
	input wire select_out, // select
	input wire [3:0] track_out // track
);
	// shorthands
	wire disk = recall_out | store_out | select_out;
	wire etx = rx_valid_in && rx_char_in == `CH_ETX;
	wire any = go_live_out | hold_next_out | sweep_abort_out | autocycle_out | disk;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	// register bus answer
	chk_ack_next: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("ack missing");
	chk_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack too long");
	chk_dat_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
		else $error("read data outside ack");
	// serial output and abort
	chk_tx_hold: assert property (tx_valid_out && !tx_ready_in && !rx_valid_in |=>
		tx_valid_out && $stable(tx_char_out)) else $error("char not held");
	chk_abort_stop: assert property (tx_valid_out && etx |=> !tx_valid_out ##1 !io_active_out)
		else $error("abort did not stop output");
	// front panel and disk pulses
	chk_hold_live: assert property (hold_next_out |-> go_live_out)
		else $error("hold without live");
	chk_live_once: assert property (go_live_out |=> !go_live_out)
		else $error("live pulse too long");
	chk_abort_alone: assert property (sweep_abort_out |-> !go_live_out && !hold_next_out)
		else $error("abort with live");
	chk_track_range: assert property (disk |-> track_out >= 4'h1 && track_out <= 4'h8)
		else $error("track out of range");
	chk_pulse_gate: assert property (any |-> io_active_out)
		else $error("pulse while inactive");
	cov_abort: cover property (tx_valid_out && etx);
	cov_store: cover property (store_out);
	cov_sweep: cover property (sweep_abort_out);
endmodule // scope_cmd_checker

bind scope_serial_command_interpreter scope_cmd_checker chk_u (.clk_in, .sys_rst_in,
	.wb_cyc_in, .wb_stb_in, .wb_dat_out, .wb_ack_out, .rx_char_in, .rx_valid_in,
	.tx_char_out, .tx_valid_out, .tx_ready_in, .io_active_out, .go_live_out,
	.hold_next_out, .sweep_abort_out, .autocycle_out, .recall_out, .store_out,
	.select_out, .track_out);

// ==== sim/host_model.sv ====
`timescale 1ns/1ps
module host_model (
	input wire clk_in, // clock
	input wire [7:0] tx_char_in, // device char
	input wire tx_valid_in, // device valid
	output logic tx_ready_out = 1'b0, // take char
	output logic [7:0] rx_char_out = 8'h00, // char to device
	output logic rx_valid_out = 1'b0 // char strobe
);
	logic [7:0] got[$];
	logic [7:0] pc = 8'h00;
	logic pend = 1'b0;
	integer seed = 32'h7f94ded7;
	integer idle = 0;
	// random stall, capture, one-cycle strobe, no stale char between strobes
	always @(posedge clk_in) begin
		tx_ready_out <= ($random(seed) & 3) != 0;
		if (tx_valid_in && tx_ready_out)
			got.push_back(tx_char_in);
		idle <= tx_valid_in ? 0 : idle + 1;
		rx_valid_out <= pend;
		rx_char_out <= pend ? pc : ~rx_char_out;
		if (pend)
			pend <= 1'b0;
	end
	// send one char: let a reply start, then wait until the device is quiet, unless now
	task automatic put(input logic [7:0] c, input logic now);
		if (!now)
			repeat (4) @(posedge clk_in);
		while (!now && idle < 8)
			@(posedge clk_in);
		pc <= c;
		pend <= 1'b1;
		@(posedge clk_in);
		@(posedge clk_in);
	endtask
endmodule // host_model

// ==== sim/scope_serial_command_interpreter_tb.sv ====
`timescale 1ns/1ps
`include "scope_cmd_map.vh"
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin err_count++; $display("mismatch %0t %s", $time, m); end end
module scope_serial_command_interpreter_tb;
	typedef logic [7:0] bq_t[$];
	logic clk_in = 1'b0, sys_rst_in = 1'b1, wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
	logic [4:0] wb_adr_in = 5'h00;
	logic [3:0] wb_sel_in = 4'h0, track_out, ptrk, ltrk = 4'h0;
	logic [31:0] wb_dat_in = 32'h0, wb_dat_out;
	logic [7:0] rx_char_in, tx_char_out, st;
	logic wb_ack_out, rx_valid_in, tx_valid_out, tx_ready_in, io_active_out, derr;
	logic go_live_out, hold_next_out, sweep_abort_out, autocycle_out, recall_out, store_out;
	logic select_out;
	logic [2:0] pmem;
	logic [11:0] smp[0:8];
	integer err_count = 0, tests_run = 0, seed = 32'h7f94ded7, cyc_n = 0, pc[7] = '{7{0}};
	wire [6:0] p = {select_out, store_out, recall_out, autocycle_out, sweep_abort_out,
		hold_next_out, go_live_out};
	always #50 clk_in = ~clk_in;
	scope_serial_command_interpreter dut_u (.clk_in, .sys_rst_in, .wb_cyc_in, .wb_stb_in,
		.wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .rx_char_in,
		.rx_valid_in, .tx_char_out, .tx_valid_out, .tx_ready_in, .io_active_out, .go_live_out,
		.hold_next_out, .sweep_abort_out, .autocycle_out, .recall_out, .store_out,
		.select_out, .track_out);
	host_model host_u (.clk_in(clk_in), .tx_char_in(tx_char_out), .tx_valid_in(tx_valid_out),
		.tx_ready_out(tx_ready_in), .rx_char_out(rx_char_in), .rx_valid_out(rx_valid_in));
	// pulse counters, last disk track, hang guard
	always @(posedge clk_in) begin
		for (int j = 0; j < 7; j++)
			if (p[j] === 1'b1)
				pc[j]++;
		if (p[6:4] !== 3'b000)
			ltrk <= track_out;
		cyc_n++;
		if (cyc_n > 60000) begin
			err_count++;
			conclude();
		end
	end
	task automatic conclude();
		if (err_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// classic wishbone single cycle
	task automatic wb(input logic [4:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		integer n;
		n = 0;
		@(posedge clk_in);
		wb_adr_in <= a;
		wb_we_in <= w;
		wb_dat_in <= d;
		wb_sel_in <= 4'hf;
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
		end while (wb_ack_out !== 1'b1 && n < 50);
		q = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		`CHK(n < 50, 1'b1, "no ack")
	endtask
	// expected encodings
	function automatic logic [7:0] dg(input integer x);
		return `CH_ZERO + x[7:0];
	endfunction
	function automatic bq_t asc(input logic [11:0] v);
		integer m;
		m = v[11] ? 4096 - v : v;
		return {v[11] ? `CH_MINUS : `CH_PLUS, dg(m / 1000), dg(m / 100 % 10), dg(m / 10 % 10),
			dg(m % 10), `CH_CR, `CH_LF};
	endfunction
	function automatic bq_t pb(input logic [11:0] v);
		return {`PB_OFFSET + {2'b00, v[11:6]}, `PB_OFFSET + {2'b00, v[5:0]}, `CH_CR, `CH_LF};
	endfunction
	function automatic bq_t term(input logic x);
		return {`CH_BAR, st | {4'h0, x, 3'b000}, `CH_CR, `CH_LF};
	endfunction
	// send a string, then wait for the device to fall quiet
	task automatic run(input bq_t s);
		host_u.got.delete();
		foreach (s[i])
			host_u.put(s[i], 1'b0);
		repeat (30) @(posedge clk_in);
		while (host_u.idle < 20)
			@(posedge clk_in);
	endtask
	task automatic cmp(input bq_t e);
		`CHK(host_u.got.size(), e.size(), "reply length")
		foreach (e[i])
			if (i < host_u.got.size())
				`CHK(host_u.got[i], e[i], "reply char")
	endtask
	// stand-alone command: k is expected pulse, 7 none, 8 not checked
	task automatic alone(input logic [7:0] l, input logic [7:0] d, input integer k,
		input logic [3:0] t);
		integer b[7];
		b = pc;
		run({`CH_SOH, l, d, `CH_ETX});
		cmp(term(1'b0));
		for (int j = 0; j < 7 && k != 8; j++)
			`CHK(pc[j] - b[j], (j == k || (k == 1 && j == 0)) ? 1 : 0, "pulses")
		if (k >= 4 && k < 7)
			`CHK(ltrk, t, "track")
	endtask
	// normalization sets from base b; read back with CR LF after each set
	task automatic nrm(input logic [7:0] d, input logic [7:0] b, input logic nin);
		bq_t s, e;
		logic [31:0] q;
		wb(`OFS_PANEL, 1'b1, {20'h0, nin, pmem, ptrk, 1'b1, derr, 2'b00}, q);
		s = {`CH_SOH, "N", d, `CH_STX};
		e = {};
		for (int k = 0; k < 216; k++) begin
			if (nin)
				s.push_back(b + 8'(k % 40));
			else
				e.push_back(b + 8'(k % 40));
			if (!nin && k % 27 == 26)
				e = {e, `CH_CR, `CH_LF};
		end
		run(s);
		cmp({e, term(1'b0)});
	endtask
	initial begin
		logic [31:0] q, w;
		bq_t e;
		integer i;
		repeat (10) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		`CHK({io_active_out, tx_valid_out, p}, 9'h000, "outputs after reset")
		wb(`OFS_PANEL, 1'b0, 32'h0, q);
		`CHK(q, {20'h0, `PANEL_RST}, "panel reset")
		wb(5'h14, 1'b0, 32'h0, q);
		`CHK(q, 32'h0, "unmapped read")
		wb(`OFS_WADDR, 1'b1, 32'h0, q);
		for (i = 0; i < 8; i++) begin
			smp[i] = $random(seed);
			wb(`OFS_WDATA, 1'b1, {20'h0, smp[i]}, q);
		end
		smp[8] = 12'h800;
		wb(`OFS_WADDR, 1'b1, 32'hfff, q);
		wb(`OFS_WDATA, 1'b1, 32'h800, q);
		w = $random(seed);
		ptrk = {1'b0, w[2:0]} + 4'h1;
		pmem = (w[5:3] == 3'h7) ? 3'h6 : w[5:3];
		derr = w[6];
		st = `STAT_BASE | {5'h0, derr, 2'b00};
		wb(`OFS_PANEL, 1'b1, {21'h0, pmem, ptrk, 1'b0, derr, 2'b00}, q);
		alone("L", "0", 0, 4'h0);
		alone("H", "0", 1, 4'h0);
		alone("H", "2", 2, 4'h0);
		alone("H", "3", 7, 4'h0);
		wb(`OFS_PANEL, 1'b1, {21'h0, pmem, ptrk, 1'b1, derr, 2'b00}, q);
		alone("H", "3", 3, 4'h0);
		for (i = 0; i < 9; i++) begin
			alone("R", dg(i), 4, (i != 0) ? 4'(i) : ptrk);
			alone("S", dg(i), 5, (i != 0) ? 4'(i) : ptrk);
			alone("T", dg(i), (i != 0) ? 6 : 7, 4'(i));
		end
		run({`CH_SOH, "L", "0", "D"});
		cmp(term(1'b1));
		run({`CH_SOH, "Z"});
		cmp(term(1'b1));
		run({`CH_SOH, "R", "9"});
		cmp(term(1'b1));
		run({`CH_SOH, "D", "4", `CH_ETX});
		cmp({st, term(1'b0)});
		run({`CH_SOH, "D", "5", `CH_ETX});
		cmp({dg(ptrk), dg(pmem), st, term(1'b0)});
		wb(`OFS_XCOUNT, 1'b1, 32'h3, q);
		run({`CH_SOH, "D", "1", "D", "0", `CH_STX, `CH_ETX});
		e = {};
		for (i = 0; i < 3; i++)
			e = {e, asc(smp[i])};
		cmp({e, term(1'b0)});
		run({`CH_SOH, "D", "3", "D", "2", `CH_STX, `CH_ETX});
		e = {};
		for (i = 0; i < 3; i++)
			e = {e, pb(smp[i])};
		cmp({e, term(1'b0)});
		wb(`OFS_XCOUNT, 1'b1, 32'h2, q);
		run({`CH_SOH, "D", "1", `CH_STX, "+", "0", "0", "0", "5", " ", "4", "0", "9", "5", `CH_ETX});
		cmp({asc(smp[5]), asc(smp[8]), term(1'b0)});
		run({`CH_SOH, "D", "3", `CH_STX, 8'h20, 8'h27, 8'ha0, 8'h22, `CH_ETX});
		cmp({pb(smp[7]), pb(smp[2]), term(1'b0)});
		run({`CH_SOH, "D", "1", `CH_STX, "+", "4", "0", "9", "6"});
		cmp(term(1'b1));
		// normalization: combined input fills both kinds, single kind input only its own
		nrm("0", 8'h30, 1'b1);
		nrm("1", 8'h30, 1'b0);
		nrm("2", 8'h30, 1'b0);
		nrm("2", 8'h41, 1'b1);
		nrm("1", 8'h30, 1'b0);
		nrm("0", 8'h30, 1'b0);
		nrm("2", 8'h41, 1'b0);
		// disk activity ending flags service in the next termination only
		wb(`OFS_PANEL, 1'b1, {21'h0, pmem, ptrk, 1'b1, derr, 2'b10}, q);
		wb(`OFS_PANEL, 1'b1, {21'h0, pmem, ptrk, 1'b1, derr, 2'b00}, q);
		run({`CH_SOH, "D", "4", `CH_ETX});
		cmp({st, `CH_BAR, st | 8'h10, `CH_CR, `CH_LF});
		run({`CH_SOH, `CH_ETX});
		cmp(term(1'b0));
		// abort in mid-output
		wb(`OFS_XCOUNT, 1'b1, 32'h8, q);
		run({`CH_SOH, "D", "0"});
		host_u.put(`CH_STX, 1'b0);
		for (i = 0; i < 500 && host_u.got.size() < 3; i++)
			@(posedge clk_in);
		`CHK(host_u.got.size() >= 3, 1'b1, "no output before abort")
		host_u.put(`CH_ETX, 1'b1);
		repeat (2) @(posedge clk_in);
		i = host_u.got.size();
		repeat (40) @(posedge clk_in);
		`CHK(host_u.got.size(), i, "output after abort")
		`CHK(io_active_out, 1'b0, "active after abort")
		conclude();
	end
endmodule // scope_serial_command_interpreter_tb
